// ===== include/usbsc_pkg.sv
package usbsc_pkg;

  // ****************************************
  // bus constants
  // ****************************************
  localparam int AXI_ADDR_W = 12;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [11:0] OFF_PIN_MUX = 12'h000;
  localparam logic [11:0] OFF_PHY_CTL = 12'h004;
  localparam logic [11:0] OFF_IO_PWDN = 12'h008;
  localparam logic [11:0] OFF_CLK_OSC = 12'h00c;
  localparam logic [11:0] OFF_EP_INDEX = 12'h010;
  localparam logic [11:0] OFF_TX_SIZE = 12'h014;
  localparam logic [11:0] OFF_RX_SIZE = 12'h018;
  localparam logic [11:0] OFF_TX_START = 12'h01c;
  localparam logic [11:0] OFF_RX_START = 12'h020;

  // ****************************************
  // field positions
  // ****************************************
  localparam int BIT_PUMP_PIN_SELECT = 31;
  localparam int BIT_LINE_POLARITY = 18;
  localparam int BIT_VBUS_SENSE = 17;
  localparam int BIT_ROLE_SELECT = 16;
  localparam int BIT_PHY_CLOCK_GOOD = 8;
  localparam int BIT_PLL_HOLD_ON = 4;
  localparam int BIT_PHY_POWER_OFF = 0;
  localparam int BIT_PUMP_PIN_PWDN = 28;
  localparam int BIT_OSC_BIAS_DISC = 25;
  localparam int BIT_OSC_DISABLE = 24;

  // writable bits of each register; the rest read zero, except clock-good bit 8 of phy control
  localparam logic [31:0] MASK_PIN_MUX = 32'h8000_0000;
  localparam logic [31:0] MASK_PHY_CTL = 32'h0007_0011;
  localparam logic [31:0] MASK_IO_PWDN = 32'h1000_0000;
  localparam logic [31:0] MASK_CLK_OSC = 32'h0300_0000;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [31:0] RST_PIN_MUX = 32'h0000_0000;
  localparam logic [31:0] RST_PHY_CTL = 32'h0004_0001;
  localparam logic [31:0] RST_IO_PWDN = 32'h0000_0000;
  localparam logic [31:0] RST_CLK_OSC = 32'h0000_0000;

  // ****************************************
  // endpoint fifo ram
  // ****************************************
  localparam int RAM_BYTES = 4096;
  localparam int RAM_WORDS = RAM_BYTES / 4;
  localparam int RAM_AW = 10;
  localparam int START_W = 9;
  localparam int SIZE_W = 5;
  localparam int BIT_DOUBLE_BUF = 4;
  localparam int IDX_W = 4;
  localparam logic [SIZE_W-1:0] EP0_SIZE = 5'h03;
  localparam logic [START_W-1:0] EP0_START = 9'h000;

  function automatic logic [31:0] usbsc_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : usbsc_merge

endpackage : usbsc_pkg

// ===== design/usbsc_fifo_alloc.sv
`timescale 1ns/1ns
module usbsc_fifo_alloc
  import usbsc_pkg::*;
#(
  parameter int NUM_EP = 5
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic wr_en_in,
  input wire logic [AXI_ADDR_W-1:0] wr_addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic [3:0] wr_strb_in,
  input wire logic [AXI_ADDR_W-1:0] rd_addr_in,
  output logic [31:0] rd_data_out,
  output logic rd_hit_out,
  output logic wr_hit_out,
  input wire logic ram_we_in,
  input wire logic [RAM_AW-1:0] ram_addr_in,
  input wire logic [31:0] ram_wdata_in,
  output logic [31:0] ram_rdata_out
);

  initial begin
    if (NUM_EP < 1 || NUM_EP > (1 << IDX_W)) begin
      $error("usbsc_fifo_alloc: NUM_EP out of range");
    end
  end

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [IDX_W-1:0] idx;
    logic [NUM_EP-1:0][SIZE_W-1:0] tx_size;
    logic [NUM_EP-1:0][SIZE_W-1:0] rx_size;
    logic [NUM_EP-1:0][START_W-1:0] tx_start;
    logic [NUM_EP-1:0][START_W-1:0] rx_start;
    logic [31:0] ram_q;
  } usbsc_fifo_st_t;

  usbsc_fifo_st_t st_reg;
  usbsc_fifo_st_t st_next;
  // one shared ram serves every endpoint
  logic [31:0] ram_mem [RAM_WORDS];

  function automatic logic [31:0] read_word(input logic [AXI_ADDR_W-1:0] a,
                                            input usbsc_fifo_st_t s);
    logic [31:0] v;
    logic ok;
    v = 32'h0;
    ok = (32'(s.idx) < NUM_EP);
    case (a)
      OFF_EP_INDEX: v = 32'(s.idx);
      OFF_TX_SIZE: v = ok ? 32'(s.tx_size[s.idx]) : 32'h0;
      OFF_RX_SIZE: v = ok ? 32'(s.rx_size[s.idx]) : 32'h0;
      OFF_TX_START: v = ok ? 32'(s.tx_start[s.idx]) : 32'h0;
      OFF_RX_START: v = ok ? 32'(s.rx_start[s.idx]) : 32'h0;
      default: v = 32'h0;
    endcase
    return v;
  endfunction : read_word

  function automatic logic in_window(input logic [AXI_ADDR_W-1:0] a);
    return (a == OFF_EP_INDEX) || (a == OFF_TX_SIZE) || (a == OFF_RX_SIZE) ||
           (a == OFF_TX_START) || (a == OFF_RX_START);
  endfunction : in_window

  assign rd_hit_out = in_window(rd_addr_in);
  assign wr_hit_out = in_window(wr_addr_in);
  assign rd_data_out = read_word(rd_addr_in, st_reg);
  assign ram_rdata_out = st_reg.ram_q;

  always_comb begin
    logic [31:0] merged;
    logic sel_ok;
    merged = usbsc_merge(read_word(wr_addr_in, st_reg), wr_data_in, wr_strb_in);
    sel_ok = (32'(st_reg.idx) < NUM_EP) && (st_reg.idx != '0);
    st_next = st_reg;
    st_next.ram_q = ram_mem[ram_addr_in];
    if (wr_en_in) begin
      // start, size, double buffer per endpoint
      // endpoint zero stays fixed; writes to it are dropped
      case (wr_addr_in)
        OFF_EP_INDEX: st_next.idx = merged[IDX_W-1:0];
        OFF_TX_SIZE: if (sel_ok) st_next.tx_size[st_reg.idx] = merged[SIZE_W-1:0];
        OFF_RX_SIZE: if (sel_ok) st_next.rx_size[st_reg.idx] = merged[SIZE_W-1:0];
        OFF_TX_START: if (sel_ok) st_next.tx_start[st_reg.idx] = merged[START_W-1:0];
        OFF_RX_START: if (sel_ok) st_next.rx_start[st_reg.idx] = merged[START_W-1:0];
        default: st_next.idx = st_reg.idx;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg <= '0;
      st_reg.tx_size[0] <= EP0_SIZE;
      st_reg.rx_size[0] <= EP0_SIZE;
    end else begin
      st_reg <= st_next;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (ram_we_in) begin
      ram_mem[ram_addr_in] <= ram_wdata_in;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  a_ep_size_store: assert property (
    (wr_en_in && wr_addr_in == OFF_TX_SIZE && wr_strb_in[0] &&
     st_reg.idx == 4'h1 && NUM_EP > 1)
    |=> st_reg.tx_size[1] == $past(wr_data_in[SIZE_W-1:0]))
    else $error("tx size of selected endpoint not stored");

  a_ep_index_route: assert property (
    (wr_en_in && wr_addr_in == OFF_RX_START && st_reg.idx == 4'h2 && NUM_EP > 2)
    |=> $stable(st_reg.rx_start[1]))
    else $error("write reached an unselected endpoint");

  a_ep0_fixed: assert property (
    st_reg.tx_size[0] == EP0_SIZE && st_reg.tx_start[0] == EP0_START)
    else $error("endpoint zero allocation changed");

endmodule : usbsc_fifo_alloc

// ===== design/usbsc_top.sv
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ns
// Function
// - pin-mux bit 31: 0 routes pump enable, 1 routes general pin 22.
// - clock-good bit 8 reads 1 when power ramped and pll locked.
// - clock-good reads 0 when power not ramped or pll unlocked.
// - pll hold bit 4 set keeps pll running through suspend.
// - phy power bit 0: 0 powers phy on, 1 off.
// - io powerdown bit 28 set powers down the shared pin cells.
// - oscillator bias bit 25 set disconnects internal bias resistor.
// - oscillator disable bit 24 set disables auxiliary oscillator.
// - pump enable driven high automatically in host role during a session.
// - pump enable held low in peripheral role.
// - one shared 4k ram holds all endpoint fifos.
// - each endpoint fifo has start, max packet size, double-buffer choice.
// - four fifo registers sit in the window selected by endpoint index.
// - role bit: 1 peripheral, 0 host.
// - polarity bit: 1 normal, 0 inverted data.
module usbsc_top
  import usbsc_pkg::*;
#(
  parameter int NUM_EP = 5
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // axi4-lite slave
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // phy status pins
  input wire logic phy_power_ramped_in,
  input wire logic phy_pll_locked_in,
  // controller core
  input wire logic session_active_in,
  input wire logic ram_we_in,
  input wire logic [RAM_AW-1:0] ram_addr_in,
  input wire logic [31:0] ram_wdata_in,
  output logic [31:0] ram_rdata_out,
  // phy and oscillator controls
  output logic phy_power_off_out,
  output logic phy_pll_hold_on_out,
  output logic line_polarity_select_out,
  output logic vbus_sense_valid_out,
  output logic role_select_out,
  output logic aux_osc_bias_disconnect_out,
  output logic aux_osc_disable_out,
  output logic pump_pin_io_powerdown_out,
  output logic vbus_pump_enable_out,
  // shared pump/gpio pin
  input wire logic shared_pin_in,
  output logic shared_pin_out,
  output logic shared_pin_oe_out,
  input wire logic general_purpose_pin_twenty_two_out_in,
  input wire logic general_purpose_pin_twenty_two_oe_in,
  output logic general_purpose_pin_twenty_two_out
);

  initial begin
    if (NUM_EP < 1 || NUM_EP > (1 << IDX_W)) begin
      $error("usbsc_top: NUM_EP out of range");
    end
  end

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic aw_hold;
    logic [AXI_ADDR_W-1:0] aw_addr;
    logic w_hold;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] pin_mux;
    logic [31:0] phy_ctl;
    logic [31:0] io_pwdn;
    logic [31:0] clk_osc;
    logic [2:0] pwr_sync;
    logic [2:0] pll_sync;
    logic pwr_ok;
    logic pll_ok;
    logic pump_en;
    logic pin_out;
    logic pin_oe;
    logic general_purpose_pin_twenty_two_in;
  } usbsc_top_st_t;

  usbsc_top_st_t st_reg;
  usbsc_top_st_t st_next;

  logic [31:0] fifo_rd_data;
  logic fifo_rd_hit;
  logic fifo_wr_hit;
  logic wr_fire;
  logic ar_fire;
  logic clock_good;

  // write commits one cycle after both halves are held
  assign wr_fire = st_reg.aw_hold && st_reg.w_hold && !st_reg.bvalid;
  assign ar_fire = s_axi_arvalid_in && !st_reg.rvalid;
  // good only with power ramped and pll locked
  assign clock_good = st_reg.pwr_ok && st_reg.pll_ok;

  usbsc_fifo_alloc #(
    .NUM_EP(NUM_EP)
  ) u_fifo_alloc (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .wr_en_in(wr_fire && fifo_wr_hit),
    .wr_addr_in(st_reg.aw_addr),
    .wr_data_in(st_reg.w_data),
    .wr_strb_in(st_reg.w_strb),
    .rd_addr_in(s_axi_araddr_in),
    .rd_data_out(fifo_rd_data),
    .rd_hit_out(fifo_rd_hit),
    .wr_hit_out(fifo_wr_hit),
    .ram_we_in(ram_we_in),
    .ram_addr_in(ram_addr_in),
    .ram_wdata_in(ram_wdata_in),
    .ram_rdata_out(ram_rdata_out)
  );

  // ****************************************
  // register read decode
  // ****************************************
  function automatic logic [32:0] sys_read(input logic [AXI_ADDR_W-1:0] a,
                                           input usbsc_top_st_t s,
                                           input logic good);
    logic [32:0] r;
    r = {1'b1, 32'h0};
    case (a)
      OFF_PIN_MUX: r = {1'b1, s.pin_mux};
      OFF_PHY_CTL: begin
        r = {1'b1, s.phy_ctl};
        r[BIT_PHY_CLOCK_GOOD] = good;
      end
      OFF_IO_PWDN: r = {1'b1, s.io_pwdn};
      OFF_CLK_OSC: r = {1'b1, s.clk_osc};
      default: r = {1'b0, 32'h0};
    endcase
    return r;
  endfunction : sys_read

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [32:0] rd;
    logic host_mode;
    rd = sys_read(s_axi_araddr_in, st_reg, clock_good);
    host_mode = 1'b0;
    st_next = st_reg;

    // axi write channels, taken in either order
    if (s_axi_awvalid_in && !st_reg.aw_hold && !st_reg.bvalid) begin
      st_next.aw_hold = 1'b1;
      st_next.aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && !st_reg.w_hold && !st_reg.bvalid) begin
      st_next.w_hold = 1'b1;
      st_next.w_data = s_axi_wdata_in;
      st_next.w_strb = s_axi_wstrb_in;
    end
    if (wr_fire) begin
      st_next.aw_hold = 1'b0;
      st_next.w_hold = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = RESP_OKAY;
      case (st_reg.aw_addr)
        OFF_PIN_MUX: st_next.pin_mux =
          usbsc_merge(st_reg.pin_mux, st_reg.w_data, st_reg.w_strb) & MASK_PIN_MUX;
        OFF_PHY_CTL: st_next.phy_ctl =
          usbsc_merge(st_reg.phy_ctl, st_reg.w_data, st_reg.w_strb) & MASK_PHY_CTL;
        OFF_IO_PWDN: st_next.io_pwdn =
          usbsc_merge(st_reg.io_pwdn, st_reg.w_data, st_reg.w_strb) & MASK_IO_PWDN;
        OFF_CLK_OSC: st_next.clk_osc =
          usbsc_merge(st_reg.clk_osc, st_reg.w_data, st_reg.w_strb) & MASK_CLK_OSC;
        default: st_next.bresp = fifo_wr_hit ? RESP_OKAY : RESP_SLVERR;
      endcase
    end else if (st_reg.bvalid && s_axi_bready_in) begin
      st_next.bvalid = 1'b0;
    end

    // axi read, answered one cycle after the address is taken
    if (ar_fire) begin
      st_next.rvalid = 1'b1;
      if (fifo_rd_hit) begin
        st_next.rdata = fifo_rd_data;
        st_next.rresp = RESP_OKAY;
      end else begin
        st_next.rdata = rd[31:0];
        st_next.rresp = rd[32] ? RESP_OKAY : RESP_SLVERR;
      end
    end else if (st_reg.rvalid && s_axi_rready_in) begin
      st_next.rvalid = 1'b0;
    end

    // pin synchronisers; a change counts once stages two and three agree
    st_next.pwr_sync = {st_reg.pwr_sync[1:0], phy_power_ramped_in};
    st_next.pll_sync = {st_reg.pll_sync[1:0], phy_pll_locked_in};
    if (st_reg.pwr_sync[1] == st_reg.pwr_sync[2]) begin
      st_next.pwr_ok = st_reg.pwr_sync[2];
    end
    if (st_reg.pll_sync[1] == st_reg.pll_sync[2]) begin
      st_next.pll_ok = st_reg.pll_sync[2];
    end

    host_mode = !st_reg.phy_ctl[BIT_ROLE_SELECT];
    // host with session drives the pump
    // peripheral role keeps the pump off
    st_next.pump_en = host_mode && session_active_in;

    // powered-down cells neither drive nor sense
    if (st_reg.io_pwdn[BIT_PUMP_PIN_PWDN]) begin
      st_next.pin_out = 1'b0;
      st_next.pin_oe = 1'b0;
      st_next.general_purpose_pin_twenty_two_in = 1'b0;
    end else if (st_reg.pin_mux[BIT_PUMP_PIN_SELECT]) begin
      st_next.pin_out = general_purpose_pin_twenty_two_out_in;
      st_next.pin_oe = general_purpose_pin_twenty_two_oe_in;
      st_next.general_purpose_pin_twenty_two_in = shared_pin_in;
    end else begin
      st_next.pin_out = st_reg.pump_en;
      st_next.pin_oe = 1'b1;
      st_next.general_purpose_pin_twenty_two_in = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg <= '0;
      st_reg.pin_mux <= RST_PIN_MUX;
      st_reg.phy_ctl <= RST_PHY_CTL;
      st_reg.io_pwdn <= RST_IO_PWDN;
      st_reg.clk_osc <= RST_CLK_OSC;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign s_axi_awready_out = !st_reg.aw_hold && !st_reg.bvalid;
  assign s_axi_wready_out = !st_reg.w_hold && !st_reg.bvalid;
  assign s_axi_bvalid_out = st_reg.bvalid;
  assign s_axi_bresp_out = st_reg.bresp;
  assign s_axi_arready_out = !st_reg.rvalid;
  assign s_axi_rvalid_out = st_reg.rvalid;
  assign s_axi_rdata_out = st_reg.rdata;
  assign s_axi_rresp_out = st_reg.rresp;

  assign phy_power_off_out = st_reg.phy_ctl[BIT_PHY_POWER_OFF];
  assign phy_pll_hold_on_out = st_reg.phy_ctl[BIT_PLL_HOLD_ON];
  assign line_polarity_select_out = st_reg.phy_ctl[BIT_LINE_POLARITY];
  assign vbus_sense_valid_out = st_reg.phy_ctl[BIT_VBUS_SENSE];
  assign role_select_out = st_reg.phy_ctl[BIT_ROLE_SELECT];
  assign aux_osc_bias_disconnect_out = st_reg.clk_osc[BIT_OSC_BIAS_DISC];
  assign aux_osc_disable_out = st_reg.clk_osc[BIT_OSC_DISABLE];
  assign pump_pin_io_powerdown_out = st_reg.io_pwdn[BIT_PUMP_PIN_PWDN];
  assign vbus_pump_enable_out = st_reg.pump_en;
  assign shared_pin_out = st_reg.pin_out;
  assign shared_pin_oe_out = st_reg.pin_oe;
  assign general_purpose_pin_twenty_two_out = st_reg.general_purpose_pin_twenty_two_in;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  a_pump_host_on: assert property (
    (!st_reg.phy_ctl[BIT_ROLE_SELECT] && session_active_in) |=> vbus_pump_enable_out)
    else $error("pump not enabled in host session");

  a_pump_periph_off: assert property (
    st_reg.phy_ctl[BIT_ROLE_SELECT] |=> !vbus_pump_enable_out)
    else $error("pump enabled in peripheral role");

  a_pin_pump_route: assert property (
    // reset-edge sample excluded: pin enable is still at its reset value there
    (rst_n_in && !st_reg.pin_mux[BIT_PUMP_PIN_SELECT] &&
     !st_reg.io_pwdn[BIT_PUMP_PIN_PWDN])
    |=> shared_pin_oe_out && shared_pin_out == $past(st_reg.pump_en))
    else $error("shared pin does not carry pump enable");

  a_pin_gpio_route: assert property (
    (st_reg.pin_mux[BIT_PUMP_PIN_SELECT] && !st_reg.io_pwdn[BIT_PUMP_PIN_PWDN])
    |=> shared_pin_out == $past(general_purpose_pin_twenty_two_out_in))
    else $error("shared pin does not carry gpio 22");

  a_pin_io_pwdn: assert property (
    st_reg.io_pwdn[BIT_PUMP_PIN_PWDN] |=> !shared_pin_oe_out)
    else $error("powered-down pin still driven");

  a_clkgood_set: assert property (
    (st_reg.pwr_sync[2:1] == 2'h3 && st_reg.pll_sync[2:1] == 2'h3) |=> clock_good)
    else $error("clock good not raised");

  a_clkgood_clear: assert property (
    (st_reg.pwr_sync[2:1] == 2'h0) |=> !clock_good ##1 !clock_good[*1])
    else $error("clock good high without power");

  a_phy_power_wr: assert property (
    (wr_fire && st_reg.aw_addr == OFF_PHY_CTL && st_reg.w_strb[0])
    |=> phy_power_off_out == $past(st_reg.w_data[BIT_PHY_POWER_OFF]))
    else $error("phy power bit not written");

  a_pll_hold_wr: assert property (
    (wr_fire && st_reg.aw_addr == OFF_PHY_CTL && st_reg.w_strb[0])
    |=> phy_pll_hold_on_out == $past(st_reg.w_data[BIT_PLL_HOLD_ON]))
    else $error("pll hold bit not written");

  a_osc_wr: assert property (
    (wr_fire && st_reg.aw_addr == OFF_CLK_OSC && st_reg.w_strb[3])
    |=> aux_osc_disable_out == $past(st_reg.w_data[BIT_OSC_DISABLE]) &&
        aux_osc_bias_disconnect_out == $past(st_reg.w_data[BIT_OSC_BIAS_DISC]))
    else $error("oscillator bits not written");

  c_pump_on: cover property (vbus_pump_enable_out && shared_pin_oe_out);
  c_gpio_mode: cover property (st_reg.pin_mux[BIT_PUMP_PIN_SELECT] && shared_pin_oe_out);
  c_clock_good: cover property (ar_fire && s_axi_araddr_in == OFF_PHY_CTL && clock_good);
  c_fifo_write: cover property (wr_fire && fifo_wr_hit);

endmodule : usbsc_top

// ===== sim/usbsc_phy_model.sv
`timescale 1ns/1ns
// ****************************************
// phy power ramp and pll lock
// ****************************************
module usbsc_phy_model #(
  parameter int RAMP_CYCLES = 4
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic phy_power_off_in,
  output logic power_ramped_out,
  output logic pll_locked_out
);
  logic [7:0] cnt_reg;
  // power only while off bit low
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_reg <= 8'h00;
    end else if (phy_power_off_in) begin
      cnt_reg <= 8'h00;
    end else if (cnt_reg != 8'hff) begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
  // lock lags the ramp, so good needs both
  assign power_ramped_out = (cnt_reg >= 8'(RAMP_CYCLES));
  assign pll_locked_out = (cnt_reg >= 8'(2 * RAMP_CYCLES));
endmodule : usbsc_phy_model

// ===== sim/usbsc_top_tb.sv
`timescale 1ns/1ns
module usbsc_top_tb
  import usbsc_pkg::*;
;
  localparam logic [11:0] OFFS [4] = '{OFF_PIN_MUX, OFF_PHY_CTL, OFF_IO_PWDN, OFF_CLK_OSC};
  localparam logic [31:0] RSTS [4] = '{RST_PIN_MUX, RST_PHY_CTL, RST_IO_PWDN, RST_CLK_OSC};
  localparam logic [31:0] MSKS [4] = '{MASK_PIN_MUX, MASK_PHY_CTL, MASK_IO_PWDN, MASK_CLK_OSC};
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, rd, ram_rd, ram_wd = '0;
  logic awv = 1'b0, wv = 1'b0, arv = 1'b0, sess = 1'b0, ram_we = 1'b0, gp_o = 1'b0, gp_oe = 1'b0;
  logic awr, wr, bv, arr, rv, ramped, locked, pin_in, gp_seen;
  logic poff, pll, pol, vsen, role, bias, odis, iopd, pump, pin_o, pin_oe;
  logic [1:0] bresp, rresp;
  logic [9:0] ram_a = '0;
  int errors = 0;
  int total_checks = 0;
  // pull-down on the shared pin when nobody drives it
  assign pin_in = pin_oe ? pin_o : 1'b0;
  always #50 clk_sys_in = ~clk_sys_in;
  usbsc_top #(.NUM_EP(5)) dut (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv), .s_axi_bready_in(1'b1),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv),
    .s_axi_rready_in(1'b1), .phy_power_ramped_in(ramped), .phy_pll_locked_in(locked),
    .session_active_in(sess), .ram_we_in(ram_we), .ram_addr_in(ram_a),
    .ram_wdata_in(ram_wd), .ram_rdata_out(ram_rd), .phy_power_off_out(poff),
    .phy_pll_hold_on_out(pll), .line_polarity_select_out(pol),
    .vbus_sense_valid_out(vsen), .role_select_out(role),
    .aux_osc_bias_disconnect_out(bias), .aux_osc_disable_out(odis),
    .pump_pin_io_powerdown_out(iopd), .vbus_pump_enable_out(pump),
    .shared_pin_in(pin_in), .shared_pin_out(pin_o), .shared_pin_oe_out(pin_oe),
    .general_purpose_pin_twenty_two_out_in(gp_o),
    .general_purpose_pin_twenty_two_oe_in(gp_oe),
    .general_purpose_pin_twenty_two_out(gp_seen));
  usbsc_phy_model phy (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .phy_power_off_in(poff), .power_ramped_out(ramped), .pll_locked_out(locked));
  // ****************************************
  // bus tasks and checks
  // ****************************************
  task automatic results;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic guard(input logic ok);
    if (ok !== 1'b1) begin
      errors++;
      results();
    end
  endtask : guard
  // ends at a falling edge so outputs are settled
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask : tick
  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_t, w_t, b_t;
    @(posedge clk_sys_in);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    b_t = 1'b0;
    // ready seen at the falling edge holds through the next rising edge
    for (int n = 0; n < 40 && !b_t; n++) begin
      @(negedge clk_sys_in);
      aw_t = awv && awr;
      w_t = wv && wr;
      b_t = bv;
      if (b_t) chk({30'h0, bresp}, {30'h0, er});
      @(posedge clk_sys_in);
      if (aw_t) awv <= 1'b0;
      if (w_t) wv <= 1'b0;
    end
    guard(b_t);
  endtask : axw
  task automatic axr(input logic [11:0] a, output logic [31:0] d, input logic [1:0] er);
    logic ar_t, r_t;
    @(posedge clk_sys_in);
    araddr <= a;
    arv <= 1'b1;
    r_t = 1'b0;
    d = '0;
    for (int n = 0; n < 40 && !r_t; n++) begin
      @(negedge clk_sys_in);
      ar_t = arv && arr;
      r_t = rv;
      d = rdata;
      if (r_t) chk({30'h0, rresp}, {30'h0, er});
      @(posedge clk_sys_in);
      if (ar_t) arv <= 1'b0;
    end
    guard(r_t);
  endtask : axr
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (10) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      axr(OFFS[i], rd, RESP_OKAY);
      chk(rd, RSTS[i]);
    end
    chk({30'h0, poff, pol}, 32'h3);
    // clear power-off and pll hold, then wait for clock good
    axw(OFF_PHY_CTL, 32'h0005_0000, RESP_OKAY);
    rd = '0;
    for (int i = 0; i < 20 && rd[8] !== 1'b1; i++) axr(OFF_PHY_CTL, rd, RESP_OKAY);
    chk(rd, 32'h0005_0100);
    @(posedge clk_sys_in);
    sess <= 1'b1;
    tick(4);
    chk({31'h0, pump}, 32'h0);
    axw(OFF_PHY_CTL, 32'h0004_0000, RESP_OKAY);
    tick(3);
    chk({29'h0, pump, pin_o, pin_oe}, 32'h7);
    @(posedge clk_sys_in);
    sess <= 1'b0;
    tick(3);
    chk({29'h0, pump, pin_o, pin_oe}, 32'h1);
    axw(OFF_PHY_CTL, 32'hffff_fffe, RESP_OKAY);
    axr(OFF_PHY_CTL, rd, RESP_OKAY);
    chk(rd, 32'h0007_0110);
    chk({28'h0, pll, vsen, role, poff}, 32'he);
    axw(OFF_PHY_CTL, 32'h0000_0001, RESP_OKAY);
    tick(8);
    axr(OFF_PHY_CTL, rd, RESP_OKAY);
    chk(rd, 32'h0000_0001);
    chk({30'h0, poff, pol}, 32'h2);
    @(posedge clk_sys_in);
    gp_o <= 1'b1;
    gp_oe <= 1'b1;
    for (int i = 0; i < 4; i += 1 + (i == 0)) begin
      axw(OFFS[i], 32'hffff_ffff, RESP_OKAY);
      axr(OFFS[i], rd, RESP_OKAY);
      chk(rd, MSKS[i]);
    end
    tick(3);
    chk({28'h0, iopd, bias, odis, pin_oe}, 32'he);
    axw(OFF_IO_PWDN, 32'h0, RESP_OKAY);
    tick(3);
    chk({29'h0, pin_o, pin_oe, gp_seen}, 32'h7);
    axw(12'h100, 32'hffff_ffff, RESP_SLVERR);
    axr(12'h100, rd, RESP_SLVERR);
    chk(rd, 32'h0);
    axw(OFF_EP_INDEX, 32'h1, RESP_OKAY);
    // ep1 tx: 128 bytes double-buffered, ending inside the 4k ram
    axw(OFF_TX_START, 32'h0000_01ef, RESP_OKAY);
    axw(OFF_TX_SIZE, 32'h0000_0013, RESP_OKAY);
    axr(OFF_TX_START, rd, RESP_OKAY);
    chk(rd, 32'h0000_01ef);
    axr(OFF_TX_SIZE, rd, RESP_OKAY);
    chk(rd, 32'h0000_0013);
    axw(OFF_EP_INDEX, 32'h2, RESP_OKAY);
    axr(OFF_TX_START, rd, RESP_OKAY);
    chk(rd, 32'h0);
    axw(OFF_RX_START, 32'h0000_0040, RESP_OKAY);
    axw(OFF_RX_SIZE, 32'h0000_0012, RESP_OKAY);
    axr(OFF_RX_START, rd, RESP_OKAY);
    chk(rd, 32'h0000_0040);
    axr(OFF_RX_SIZE, rd, RESP_OKAY);
    chk(rd, 32'h0000_0012);
    axw(OFF_EP_INDEX, 32'h1, RESP_OKAY);
    axr(OFF_RX_START, rd, RESP_OKAY);
    chk(rd, 32'h0);
    axw(OFF_EP_INDEX, 32'h0, RESP_OKAY);
    axw(OFF_TX_SIZE, 32'h0000_001f, RESP_OKAY);
    axr(OFF_TX_SIZE, rd, RESP_OKAY);
    chk(rd, {27'h0, EP0_SIZE});
    @(posedge clk_sys_in);
    ram_a <= 10'h3ff;
    ram_wd <= 32'ha5c3_3c5a;
    ram_we <= 1'b1;
    @(posedge clk_sys_in);
    ram_we <= 1'b0;
    tick(2);
    chk(ram_rd, 32'ha5c3_3c5a);
    results();
  end
endmodule : usbsc_top_tb
